/* common/qec_pkg.sv */
// shared constants and types of the quadrature encoder capture block
package qec_pkg;
    // structure
    localparam int QEC_CHANNELS = 4;
    localparam int QEC_CNT_W = 32;
    localparam int QEC_ADDR_W = 8;
    localparam int QEC_IN_W = 3 * QEC_CHANNELS + 2;
    typedef logic [QEC_ADDR_W-1:0] qec_addr_t;

    // register byte addresses, count and capture banks step by four per channel
    localparam qec_addr_t QEC_OFS_COUNT = 8'h00;
    localparam qec_addr_t QEC_OFS_LATCH = 8'h10;
    localparam qec_addr_t QEC_OFS_CFG = 8'h20;
    localparam qec_addr_t QEC_OFS_STATUS = 8'h24;
    localparam qec_addr_t QEC_OFS_CMD = 8'h28;
    localparam qec_addr_t QEC_OFS_IRQ_STAT = 8'h2C;
    localparam qec_addr_t QEC_OFS_IRQ_MASK = 8'h30;

    // configuration fields
    localparam int QEC_CFG_MODE_LSB = 0;
    localparam int QEC_CFG_EDGE_BIT = 8;
    localparam int QEC_CFG_TSEL_BIT = 9;
    localparam int QEC_CFG_IDX_EN_LSB = 12;
    localparam int QEC_CFG_IDX_LVL_LSB = 16;

    // command bits, write one to act
    localparam int QEC_CMD_REARM_BIT = 0;
    localparam int QEC_CMD_IDX_CLR_BIT = 1;
    localparam int QEC_CMD_CNT_CLR_BIT = 2;

    // status fields
    localparam int QEC_ST_TRG_LSB = 0;
    localparam int QEC_ST_IDX_LSB = 4;
    localparam int QEC_ST_LAT_LSB = 8;
    localparam int QEC_ST_CLR_LSB = 12;

    // interrupt fields: capture events low, index resets high
    localparam int QEC_IRQ_CAP_LSB = 0;
    localparam int QEC_IRQ_IDX_LSB = 4;
    localparam int QEC_IRQ_W = 8;

    // reset values
    localparam logic [31:0] QEC_ZERO = 32'h0000_0000;
    localparam logic [QEC_IRQ_W-1:0] QEC_IRQ_RESET = 8'h00;

    // counting modes
    typedef enum logic [1:0] {
        QEC_MODE_STEP_DIR = 2'h0,
        QEC_MODE_X1 = 2'h1,
        QEC_MODE_X2 = 2'h2,
        QEC_MODE_X4 = 2'h3
    } qec_mode_t;
endpackage

/* common/qec_sig_if.sv */
// synchronised input levels and their edge pulses
`timescale 1ns/1ps
`default_nettype none
interface qec_sig_if #(parameter int W = 14);
    logic [W-1:0] level;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

/* src/qec_sync.sv */
// three-stage input synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module qec_sync #(
    parameter int W = 14
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [W-1:0] raw,
    qec_sig_if.src sig
);
    import qec_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] level;
        logic [W-1:0] rise;
        logic [W-1:0] fall;
    } qec_sync_st_t;

    qec_sync_st_t st;
    qec_sync_st_t next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = raw;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // take a new level only where stages two and three agree
        next_st.level = (st.s2 & ~(st.s2 ^ st.s3)) | (st.level & (st.s2 ^ st.s3));
        next_st.rise = next_st.level & ~st.level;
        next_st.fall = ~next_st.level & st.level;
    end

    // state register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sig.level = st.level;
    assign sig.rise = st.rise;
    assign sig.fall = st.fall;

    property p_edge_agreed;
        @(posedge mclk) disable iff (sys_rst)
        (|st.rise) |-> (($past(st.s2 & st.s3) & st.rise) == st.rise);
    endproperty
    a_edge_agreed: assert property (p_edge_agreed) else $error("rise without agreed stages");
endmodule
`default_nettype wire

/* src/qec_top.sv */
// top of the quadrature encoder capture block: counters, capture, avalon-mm registers
// Operation
// - four 32-bit counters, one per channel, full count readable by host
// - host write loads a live counter, its capture register untouched
// - each trigger event copies all four counters into capture registers
// - host read of capture register returns latest transferred count
// - capture done by logic alone, fixed short delay after trigger edge
// - per channel index counter reset, enable and active level selectable
// - host commands re-arm captures, clear index flags, clear counters
// - mode 0 step/direction, modes 1 to 3 count x1, x2, x4
// - trigger edge select: 0 rising edge, 1 falling edge
// - set captured flag blocks further captures until host re-arms
// - one trigger input used at a time, first input after reset
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module qec_top (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [qec_pkg::QEC_CHANNELS-1:0] phase_a_input,
    input wire logic [qec_pkg::QEC_CHANNELS-1:0] phase_b_input,
    input wire logic [qec_pkg::QEC_CHANNELS-1:0] index_input,
    input wire logic trigger_input_first,
    input wire logic trigger_input_second,
    input wire qec_pkg::qec_addr_t avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq
);
    import qec_pkg::*;

    typedef struct packed {
        logic [QEC_CHANNELS-1:0][QEC_CNT_W-1:0] cnt;
        logic [QEC_CHANNELS-1:0][QEC_CNT_W-1:0] lat;
        logic [QEC_CHANNELS-1:0] lat_flag;
        logic [QEC_CHANNELS-1:0] idx_flag;
        logic [QEC_CHANNELS-1:0][1:0] mode;
        logic trg_fall;
        logic tsel;
        logic [QEC_CHANNELS-1:0] idx_en;
        logic [QEC_CHANNELS-1:0] idx_lvl;
        logic [QEC_IRQ_W-1:0] irq_stat;
        logic [QEC_IRQ_W-1:0] irq_mask;
        logic ack;
        logic waitreq;
        logic [31:0] rdata;
        logic irq;
    } qec_state_t;

    qec_state_t st;
    qec_state_t next_st;

    // address match of a per-channel register
    function automatic logic qec_at(input qec_addr_t addr, input qec_addr_t base, input int idx);
        return addr == qec_addr_t'(base + qec_addr_t'(4 * idx));
    endfunction

    // up/down decision for one channel, returned as {up, down}
    function automatic logic [1:0] qec_step(input qec_mode_t m, input logic a, input logic b,
                                            input logic ar, input logic af, input logic br, input logic bf);
        logic up;
        logic dn;
        up = 1'b0;
        dn = 1'b0;
        unique case (m)
            QEC_MODE_STEP_DIR: begin
                up = ar & b;
                dn = ar & ~b;
            end
            QEC_MODE_X1: begin
                up = ar & ~b;
                dn = af & ~b;
            end
            QEC_MODE_X2: begin
                up = (ar | af) & (a ^ b);
                dn = (ar | af) & ~(a ^ b);
            end
            QEC_MODE_X4: begin
                up = ((ar | af) & (a ^ b)) | ((br | bf) & ~(a ^ b));
                dn = ((ar | af) & ~(a ^ b)) | ((br | bf) & (a ^ b));
            end
        endcase
        return {up, dn};
    endfunction

    qec_sig_if #(.W(QEC_IN_W)) pins ();
    qec_sync #(.W(QEC_IN_W)) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .raw({trigger_input_second, trigger_input_first, index_input, phase_b_input, phase_a_input}),
        .sig(pins.src)
    );

    // synchronised views of the pins
    logic [QEC_CHANNELS-1:0] a_lvl;
    logic [QEC_CHANNELS-1:0] b_lvl;
    logic [QEC_CHANNELS-1:0] a_rise;
    logic [QEC_CHANNELS-1:0] a_fall;
    logic [QEC_CHANNELS-1:0] b_rise;
    logic [QEC_CHANNELS-1:0] b_fall;
    logic [QEC_CHANNELS-1:0] idx_in;
    logic trg_lvl;
    logic trg_rise_ev;
    logic trg_fall_ev;
    logic trg_pulse;
    assign a_lvl = pins.level[3:0];
    assign b_lvl = pins.level[7:4];
    assign a_rise = pins.rise[3:0];
    assign a_fall = pins.fall[3:0];
    assign b_rise = pins.rise[7:4];
    assign b_fall = pins.fall[7:4];
    assign idx_in = pins.level[11:8];

    // one trigger input at a time
    assign trg_lvl = st.tsel ? pins.level[13] : pins.level[12];
    assign trg_rise_ev = st.tsel ? pins.rise[13] : pins.rise[12];
    assign trg_fall_ev = st.tsel ? pins.fall[13] : pins.fall[12];
    assign trg_pulse = st.trg_fall ? trg_fall_ev : trg_rise_ev;

    // bus write qualifier and command decode
    logic wr_hit;
    logic cmd_rearm;
    logic cmd_idx_clr;
    logic cmd_cnt_clr;
    assign wr_hit = avs_write & st.ack;
    assign cmd_rearm = wr_hit && (avs_address == QEC_OFS_CMD) && avs_writedata[QEC_CMD_REARM_BIT];
    assign cmd_idx_clr = wr_hit && (avs_address == QEC_OFS_CMD) && avs_writedata[QEC_CMD_IDX_CLR_BIT];
    assign cmd_cnt_clr = wr_hit && (avs_address == QEC_OFS_CMD) && avs_writedata[QEC_CMD_CNT_CLR_BIT];

    // readback words of the configuration and status registers
    logic [31:0] cfg_word;
    logic [31:0] status_word;
    always_comb begin
        cfg_word = QEC_ZERO;
        cfg_word[QEC_CFG_MODE_LSB +: 2*QEC_CHANNELS] = st.mode;
        cfg_word[QEC_CFG_EDGE_BIT] = st.trg_fall;
        cfg_word[QEC_CFG_TSEL_BIT] = st.tsel;
        cfg_word[QEC_CFG_IDX_EN_LSB +: QEC_CHANNELS] = st.idx_en;
        cfg_word[QEC_CFG_IDX_LVL_LSB +: QEC_CHANNELS] = st.idx_lvl;
        status_word = QEC_ZERO;
        status_word[QEC_ST_TRG_LSB +: QEC_CHANNELS] = {QEC_CHANNELS{trg_lvl ^ st.trg_fall}};
        status_word[QEC_ST_IDX_LSB +: QEC_CHANNELS] = idx_in ^ st.idx_lvl;
        status_word[QEC_ST_LAT_LSB +: QEC_CHANNELS] = st.lat_flag;
        status_word[QEC_ST_CLR_LSB +: QEC_CHANNELS] = st.idx_flag;
    end

    // next state: bus, configuration, counters, capture, interrupts
    always_comb begin
        logic [31:0] rd;
        logic [QEC_CHANNELS-1:0] cap;
        logic [QEC_CHANNELS-1:0] hit;
        logic [1:0] stp;
        logic [QEC_IRQ_W-1:0] w1c;
        rd = QEC_ZERO;
        cap = 4'h0;
        hit = 4'h0;
        stp = 2'h0;
        w1c = QEC_IRQ_RESET;
        next_st = st;
        // one wait cycle, then a single acknowledge cycle
        next_st.ack = (avs_read | avs_write) & ~st.ack;
        next_st.waitreq = ~next_st.ack; // kept in a flop so the pin is registered
        // read decode, unmapped reads as zero
        for (int i = 0; i < QEC_CHANNELS; i++) begin
            if (qec_at(avs_address, QEC_OFS_COUNT, i)) begin
                rd = st.cnt[i];
            end
            if (qec_at(avs_address, QEC_OFS_LATCH, i)) begin
                rd = st.lat[i];
            end
        end
        case (avs_address)
            QEC_OFS_CFG: rd = cfg_word;
            QEC_OFS_STATUS: rd = status_word;
            QEC_OFS_IRQ_STAT: rd = {24'h00_0000, st.irq_stat};
            QEC_OFS_IRQ_MASK: rd = {24'h00_0000, st.irq_mask};
            default: ;
        endcase
        if (avs_read & ~st.ack) begin
            next_st.rdata = rd;
        end
        // configuration writes
        if (wr_hit && (avs_address == QEC_OFS_CFG)) begin
            next_st.mode = avs_writedata[QEC_CFG_MODE_LSB +: 2*QEC_CHANNELS];
            next_st.trg_fall = avs_writedata[QEC_CFG_EDGE_BIT];
            next_st.tsel = st.tsel | avs_writedata[QEC_CFG_TSEL_BIT];
            next_st.idx_en = avs_writedata[QEC_CFG_IDX_EN_LSB +: QEC_CHANNELS];
            next_st.idx_lvl = avs_writedata[QEC_CFG_IDX_LVL_LSB +: QEC_CHANNELS];
        end
        if (wr_hit && (avs_address == QEC_OFS_IRQ_MASK)) begin
            next_st.irq_mask = avs_writedata[QEC_IRQ_W-1:0];
        end
        if (wr_hit && (avs_address == QEC_OFS_IRQ_STAT)) begin
            w1c = avs_writedata[QEC_IRQ_W-1:0];
        end
        for (int i = 0; i < QEC_CHANNELS; i++) begin
            // index reset at the chosen level
            hit[i] = st.idx_en[i] & (idx_in[i] == st.idx_lvl[i]);
            cap[i] = trg_pulse & ~st.lat_flag[i];
            stp = qec_step(qec_mode_t'(st.mode[i]), a_lvl[i], b_lvl[i],
                           a_rise[i], a_fall[i], b_rise[i], b_fall[i]);
            // re-arm, a capture in the same cycle wins
            if (cmd_rearm) begin
                next_st.lat_flag[i] = 1'b0;
            end
            if (cap[i]) begin
                next_st.lat_flag[i] = 1'b1;
                next_st.lat[i] = st.cnt[i];
            end
            // index flag clear, new index reset wins
            if (cmd_idx_clr) begin
                next_st.idx_flag[i] = 1'b0;
            end
            if (hit[i]) begin
                next_st.idx_flag[i] = 1'b1;
            end
            // host load first, then clears, then counting
            if (wr_hit && qec_at(avs_address, QEC_OFS_COUNT, i)) begin
                next_st.cnt[i] = avs_writedata;
            end else if (cmd_cnt_clr || hit[i]) begin
                next_st.cnt[i] = QEC_ZERO;
            end else if (stp == 2'b10) begin
                next_st.cnt[i] = st.cnt[i] + 32'h0000_0001;
            end else if (stp == 2'b01) begin
                next_st.cnt[i] = st.cnt[i] - 32'h0000_0001;
            end
        end
        // sticky events, write one to clear, setting wins
        next_st.irq_stat = (st.irq_stat & ~w1c) | {hit, cap};
        next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
    end

    // state register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st <= '{waitreq: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata = st.rdata;
    assign avs_waitrequest = st.waitreq;
    assign irq = st.irq;

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    logic rd_cnt0;
    logic rd_lat0;
    logic wr_cnt1;
    assign rd_cnt0 = avs_read && !st.ack && (avs_address == QEC_OFS_COUNT);
    assign rd_lat0 = avs_read && !st.ack && (avs_address == QEC_OFS_LATCH);
    assign wr_cnt1 = wr_hit && qec_at(avs_address, QEC_OFS_COUNT, 1);

    property p_count_read;
        rd_cnt0 |=> (avs_readdata == $past(st.cnt[0])) && !avs_waitrequest;
    endproperty
    a_count_read: assert property (p_count_read) else $error("count read mismatch");

    property p_count_load;
        wr_cnt1 |=> (st.cnt[1] == $past(avs_writedata)) && $stable(st.lat[1]);
    endproperty
    a_count_load: assert property (p_count_load) else $error("count load wrong");

    property p_capture_all;
        (trg_pulse && (st.lat_flag == 4'h0)) |=> (st.lat_flag == 4'hF);
    endproperty
    a_capture_all: assert property (p_capture_all) else $error("not all channels captured");

    property p_latch_read;
        rd_lat0 |=> ##0 (avs_readdata == $past(st.lat[0])) ##1 avs_waitrequest;
    endproperty
    a_latch_read: assert property (p_latch_read) else $error("capture read mismatch");

    property p_capture_value;
        (trg_pulse && !st.lat_flag[2]) |=> (st.lat[2] == $past(st.cnt[2]));
    endproperty
    a_capture_value: assert property (p_capture_value) else $error("captured value wrong");

    property p_index_zero;
        (st.idx_en[0] && (idx_in[0] == st.idx_lvl[0]) && !wr_hit) |=> (st.cnt[0] == QEC_ZERO) && st.idx_flag[0];
    endproperty
    a_index_zero: assert property (p_index_zero) else $error("index reset missed");

    property p_rearm;
        (cmd_rearm && !trg_pulse) |=> (st.lat_flag == 4'h0);
    endproperty
    a_rearm: assert property (p_rearm) else $error("re-arm ignored");

    property p_step_dir;
        ((st.mode[0] == QEC_MODE_STEP_DIR) && a_rise[0] && b_lvl[0] && !st.idx_en[0] && !wr_hit)
            |=> (st.cnt[0] == $past(st.cnt[0]) + 32'h0000_0001);
    endproperty
    a_step_dir: assert property (p_step_dir) else $error("step count wrong");

    property p_trig_edge;
        $rose(st.lat_flag[1]) |-> $past(st.trg_fall ? trg_fall_ev : trg_rise_ev);
    endproperty
    a_trig_edge: assert property (p_trig_edge) else $error("capture on wrong edge");

    property p_hold;
        (st.lat_flag[0] && !cmd_rearm) |=> st.lat_flag[0] && $stable(st.lat[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("captured value overwritten");

    property p_tsel_sticky;
        st.tsel |=> st.tsel;
    endproperty
    a_tsel_sticky: assert property (p_tsel_sticky) else $error("trigger select went back");

    property p_one_wait;
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bus answer not after one wait cycle");

    property p_irq_sticky;
        (st.irq_stat[0] && !(wr_hit && (avs_address == QEC_OFS_IRQ_STAT) && avs_writedata[0]))
            |=> st.irq_stat[0];
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("capture event bit lost");

    property p_count_clear;
        cmd_cnt_clr |=> (st.cnt[2] == QEC_ZERO);
    endproperty
    a_count_clear: assert property (p_count_clear) else $error("counter clear ignored");

    property p_x1_down;
        ((st.mode[1] == QEC_MODE_X1) && a_fall[1] && !b_lvl[1] && !st.idx_en[1] && !wr_hit)
            |=> (st.cnt[1] == $past(st.cnt[1]) - 32'h0000_0001);
    endproperty
    a_x1_down: assert property (p_x1_down) else $error("x1 down count wrong");

    c_capture: cover property (trg_pulse && (st.lat_flag == 4'h0));
    c_index: cover property (st.idx_en[0] && $rose(st.idx_flag[0]));
    c_x4: cover property ((st.mode[1] == QEC_MODE_X4) && (b_rise[1] || b_fall[1]));
    c_second_trigger: cover property (st.tsel && trg_pulse);
    c_count_load: cover property (wr_cnt1);
endmodule
`default_nettype wire

/* dv/qec_enc_model.sv */
// encoder, index and trigger source model driving the block's pins
`timescale 1ns/1ps
`default_nettype none
module qec_enc_model (
    input wire logic mclk,
    output logic [3:0] phase_a,
    output logic [3:0] phase_b,
    output logic [3:0] index,
    output logic trig_first,
    output logic trig_second
);
    // all pins low from time zero, no edge seen at reset release
    initial begin
        phase_a = 4'h0;
        phase_b = 4'h0;
        index = 4'h0;
        trig_first = 1'b0;
        trig_second = 1'b0;
    end

    // one quarter step on every channel, only one phase moves
    task automatic quad(input logic up);
        @(posedge mclk);
        if (phase_a[0] ^ phase_b[0] ^ up)
            phase_a <= ~phase_a;
        else
            phase_b <= ~phase_b;
        // levels held well past the input filter
        repeat (5) @(posedge mclk);
    endtask

    // set trigger and index levels, {second, first, index[3:0]}
    task automatic pins(input logic [5:0] v);
        @(posedge mclk);
        {trig_second, trig_first, index} <= v;
        repeat (7) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

/* dv/qec_top_bench.sv */
// self-checking bench of the quadrature encoder capture block
`timescale 1ns/1ps
`default_nettype none
module qec_top_bench;
    import qec_pkg::*;
    logic mclk;
    logic sys_rst;
    wire logic [3:0] pa;
    wire logic [3:0] pb;
    wire logic [3:0] pz;
    wire logic t1;
    wire logic t2;
    qec_addr_t avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    int fails;
    int checks;
    int cnt [4];
    logic [31:0] lat [4];
    logic [3:0] capf;
    logic [3:0] idxf;
    logic [7:0] ist;
    logic [7:0] imask;
    logic [31:0] cfg;
    logic [5:0] pv;
    logic [31:0] q;
    logic [31:0] seed_v;

    // 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    qec_top DUT (.mclk(mclk), .sys_rst(sys_rst), .phase_a_input(pa), .phase_b_input(pb), .index_input(pz),
        .trigger_input_first(t1), .trigger_input_second(t2), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq));
    qec_enc_model enc (.mclk(mclk), .phase_a(pa), .phase_b(pb), .index(pz), .trig_first(t1), .trig_second(t2));

    // compare one register word
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // compare the interrupt level after it has settled
    task automatic chk_irq();
        repeat (2) @(posedge mclk);
        checks++;
        if (irq !== ((ist & imask) != 8'h00)) begin
            fails++;
            $display("[ERR] irq expected %b seen %b", (ist & imask) != 8'h00, irq);
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input qec_addr_t a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        chk("wait cycles", 32'h0000_0002, 32'(n));
    endtask

    // count change of one channel for one pin transition
    function automatic int delta(input int m, input logic oa, input logic ob, input logic na, input logic nb);
        if (m == 0)
            return (!oa && na) ? (nb ? 1 : -1) : 0;
        if (m == 1)
            return (!ob && oa != na) ? (na ? 1 : -1) : 0;
        if (oa != na)
            return (na != nb) ? 1 : -1;
        return (m == 3 && ob != nb) ? ((na == nb) ? 1 : -1) : 0;
    endfunction

    // expected register contents from the bench model
    function automatic logic [31:0] expect_reg(input qec_addr_t a);
        logic [3:0] tl;
        tl = {4{(cfg[9] ? pv[5] : pv[4]) ^ cfg[8]}};
        if (a[7:4] == 4'h0)
            return 32'(cnt[a[3:2]]);
        if (a[7:4] == 4'h1)
            return lat[a[3:2]];
        case (a)
            QEC_OFS_CFG: return cfg;
            QEC_OFS_STATUS: return {16'h0000, idxf, capf, pv[3:0] ^ cfg[19:16], tl};
            QEC_OFS_IRQ_STAT: return {24'h00_0000, ist};
            QEC_OFS_IRQ_MASK: return {24'h00_0000, imask};
            default: return 32'h0000_0000;
        endcase
    endfunction

    // register write on the bus and in the model
    task automatic wr(input qec_addr_t a, input logic [31:0] d);
        bus(1'b1, a, d);
        if (a < QEC_OFS_LATCH)
            cnt[a[3:2]] = d;
        if (a == QEC_OFS_CFG)
            cfg = (d & 32'h000F_F3FF) | (cfg & 32'h0000_0200);
        if (a == QEC_OFS_CMD) begin
            if (d[0])
                capf = 4'h0;
            if (d[1])
                idxf = 4'h0;
            if (d[2])
                cnt = '{default: 0};
        end
        if (a == QEC_OFS_IRQ_STAT)
            ist = ist & ~d[7:0];
        if (a == QEC_OFS_IRQ_MASK)
            imask = d[7:0];
    endtask

    // read the whole map, four unmapped words included
    task automatic rd_all();
        for (int a = 0; a <= 'h40; a += 4) begin
            bus(1'b0, 8'(a), 32'h0000_0000);
            chk($sformatf("reg %h", a), expect_reg(8'(a)), q);
        end
        chk_irq();
    endtask

    // one encoder quarter step, all channels counted by mode
    task automatic step(input logic up);
        logic oa;
        logic ob;
        oa = pa[0];
        ob = pb[0];
        enc.quad(up);
        for (int n = 0; n < 4; n++)
            cnt[n] += delta(int'(cfg[2*n +: 2]), oa, ob, pa[0], pb[0]);
    endtask

    // new trigger and index levels, capture and index reset in the model
    task automatic setpins(input logic [5:0] v);
        logic os;
        logic ns;
        os = cfg[9] ? pv[5] : pv[4];
        ns = cfg[9] ? v[5] : v[4];
        pv = v;
        enc.pins(v);
        if (os != ns && ns != cfg[8]) begin
            for (int n = 0; n < 4; n++)
                if (!capf[n])
                    lat[n] = cnt[n];
            ist[3:0] = ist[3:0] | ~capf;
            capf = 4'hF;
        end
        for (int n = 0; n < 4; n++)
            if (cfg[12+n] && v[n] == cfg[16+n]) begin
                cnt[n] = 0;
                idxf[n] = 1'b1;
                ist[4+n] = 1'b1;
            end
    endtask

    // final counts and verdict
    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (40000) @(posedge mclk);
        fails++;
        give_verdict();
    end

    // main sequence
    initial begin
        seed_v = $urandom(32'h78d5);
        fails = 0;
        checks = 0;
        sys_rst = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        cnt = '{default: 0};
        lat = '{default: 32'h0000_0000};
        capf = 4'h0;
        idxf = 4'h0;
        ist = 8'h00;
        imask = 8'h00;
        cfg = 32'h0000_0000;
        pv = 6'h00;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        rd_all();
        wr(QEC_OFS_CFG, 32'h0000_00E4);
        repeat (40) step(1'($urandom % 2));
        rd_all();
        for (int n = 0; n < 4; n++)
            wr(8'(4*n), $urandom);
        wr(QEC_OFS_IRQ_MASK, 32'h0000_00FF);
        setpins(6'h10);
        setpins(6'h00);
        rd_all();
        repeat (8) step(1'b1);
        wr(QEC_OFS_COUNT + 8'h04, $urandom);
        setpins(6'h10);
        setpins(6'h00);
        rd_all();
        wr(QEC_OFS_CMD, 32'h0000_0001);
        wr(QEC_OFS_IRQ_STAT, 32'h0000_00FF);
        wr(QEC_OFS_CFG, cfg | 32'h0000_0100);
        setpins(6'h10);
        rd_all();
        setpins(6'h00);
        rd_all();
        wr(QEC_OFS_CMD, 32'h0000_0001);
        wr(QEC_OFS_CFG, cfg | 32'h0000_0200);
        wr(QEC_OFS_CFG, cfg & ~32'h0000_0200);
        setpins(6'h10);
        setpins(6'h00);
        rd_all();
        setpins(6'h20);
        setpins(6'h00);
        rd_all();
        wr(QEC_OFS_CFG, cfg | 32'h0001_1000);
        setpins(6'h01);
        rd_all();
        setpins(6'h00);
        repeat (6) step(1'b1);
        wr(QEC_OFS_CMD, 32'h0000_0002);
        rd_all();
        wr(QEC_OFS_CMD, 32'h0000_0004);
        rd_all();
        give_verdict();
    end
endmodule
`default_nettype wire
